// file: hdl/freq_meas_counter.v
// counts variable rc oscillator ticks over a window of crystal input edges
// assumes tick and reference edges are single-cycle pulses in ref_clk
module freq_meas_counter #(
   parameter GATE_EDGES = 16'h0100
)(
   input  wire        ref_clk,
   input  wire        sys_rst,
   input  wire        start,
   input  wire        osc_tick,
   input  wire        ref_edge,
   output wire        busy,
   output reg  [15:0] count
);
   reg [15:0] gate_reg;
   reg [15:0] acc_reg;
   reg        busy_reg;

   assign busy = busy_reg;

   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         gate_reg <= 16'h0000;
         acc_reg  <= 16'h0000;
         busy_reg <= 1'b0;
         count    <= 16'h0000;
      end
      else if (start && !busy_reg)
      begin
         gate_reg <= GATE_EDGES;
         acc_reg  <= 16'h0000;
         busy_reg <= 1'b1;
      end
      else if (busy_reg)
      begin
         if (osc_tick)
            acc_reg <= acc_reg + 16'h0001; // rc frequency against crystal reference
         if (ref_edge)
         begin
            if (gate_reg == 16'h0001)
            begin
               busy_reg <= 1'b0;
               count    <= acc_reg + {15'h0000, osc_tick};
            end
            gate_reg <= gate_reg - 16'h0001;
         end
      end
   end
endmodule // freq_meas_counter

// file: hdl/standby_wake_reset_ctrl.v
// standby mode, wake source, clock divider and reset sequencer
// assumes inputs synchronous to ref_clk; avalon-mm slave with waitrequest
// How it works
// - halt stops cpu, peripherals keep clocking
// - halt leaves all oscillators running
// - halt ends on reset, watchdog, interrupt
// - hold stops cpu and all peripherals
// - hold stops ceramic, rc, crystal, variable rc
// - hold wakes on pins, port0, serial byte
// - crystal hold keeps only base timer running
// - crystal hold stops ceramic and rc oscillators
// - crystal hold retains crystal oscillator state
// - crystal hold adds base timer, calendar wakes
// - crystal hold offers power-save variant
// - divider picks nine binary cycle steps
// - power-on reset only at power-up
// - low-voltage reset combines with power-on reset
// - low-voltage use fixed by option, not registers
// - measure variable rc against crystal input
// - serial wake after eight transfer clocks
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`include "standby_wake_reset_ctrl_defines.vh"
module standby_wake_reset_ctrl #(
   parameter OSC_SETTLE_CYCLES = `OSC_SETTLE_CYCLES,
   parameter SYS_RESET_CYCLES  = `SYS_RESET_CYCLES
)(
   input  wire        ref_clk,
   input  wire        sys_rst,
   // avalon-mm slave
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // reset sources
   input  wire        reset_pin_n,
   input  wire        watchdog_reset,
   input  wire        power_on_detect,
   input  wire        supply_low_detect,
   input  wire        low_voltage_detect_reset,
   // wake sources
   input  wire        ext_irq_pin_a,
   input  wire        ext_irq_pin_b,
   input  wire        ext_irq_pin_c,
   input  wire        ext_irq_pin_d,
   input  wire        ext_irq_pin_e,
   input  wire        ext_irq_pin_f,
   input  wire        port0_irq,
   input  wire        serial_clk_edge,
   input  wire        serial_rx_active,
   input  wire        base_timer_irq,
   input  wire        calendar_irq,
   input  wire        any_irq_accepted,
   // measurement inputs
   input  wire        var_rc_tick,
   input  wire        crystal_in_pin,
   // outputs to core and peripherals
   output reg         cpu_run,
   output reg         periph_clk_en,
   output reg         base_timer_clk_en,
   output reg         ceramic_oscillator,
   output reg         rc_osc_en,
   output reg         crystal_osc_en,
   output reg         var_rc_osc_en,
   output reg         power_save,
   output reg         system_reset,
   output reg         wake_irq_pending,
   output reg         cycle_enable
);
   // states, one-hot
   localparam ST_RUN   = 6'b000001;
   localparam ST_HALT  = 6'b000010;
   localparam ST_HOLD  = 6'b000100;
   localparam ST_XHOLD = 6'b001000;
   localparam ST_SETTL = 6'b010000;
   localparam ST_RESET = 6'b100000;

   reg  [5:0]  state_reg;
   reg  [5:0]  state_next;
   reg  [15:0] settle_reg;
   reg  [4:0]  rst_cnt_reg;
   reg  [3:0]  div_sel_reg;
   reg         xtal_en_reg;
   reg         power_save_reg;
   reg         xtal_keep_reg;
   reg  [3:0]  serial_cnt_reg;
   reg         serial_byte_reg;
   reg  [11:0] div_cnt_reg;
   reg         por_seen_reg;
   reg         ack_reg;
   reg         xtal_prev_reg;
   reg         mode_cmd_valid;
   reg  [1:0]  mode_cmd;
   wire        meas_busy;
   wire [15:0] meas_count;
   wire        ref_edge;
   wire        reset_wake;
   wire        pin_wake;
   wire        hold_wake;
   wire        xhold_wake;
   wire        por_reset;
   wire        lvd_reset;
   wire        wr_sel;
   wire        rd_sel;

   // address decode shared by read and write
   function sel;
      input [3:0] addr;
      input [3:0] target;
      begin
         sel = (addr == target);
      end
   endfunction

   assign ref_edge   = crystal_in_pin & ~xtal_prev_reg;
   // power-on reset is taken once, low-voltage only when optioned
   assign por_reset  = power_on_detect & ~por_seen_reg;
   assign lvd_reset  = low_voltage_detect_reset & supply_low_detect; // option pin, no register
   assign reset_wake = ~reset_pin_n | watchdog_reset | por_reset | lvd_reset;
   assign pin_wake   = ext_irq_pin_a | ext_irq_pin_b | ext_irq_pin_c |
                       ext_irq_pin_d | ext_irq_pin_e | ext_irq_pin_f;
   assign hold_wake  = pin_wake | port0_irq | serial_byte_reg;
   assign xhold_wake = hold_wake | base_timer_irq | calendar_irq;

   // a write answers one cycle late so it lands at the edge waitrequest drops
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign wr_sel = avs_write & ack_reg & avs_byteenable[0];
   assign rd_sel = avs_read & ~ack_reg;

   always @*
   begin
      mode_cmd_valid = wr_sel & sel(avs_address, `ADDR_MODE_CTRL) & (state_reg == ST_RUN);
      mode_cmd       = avs_writedata[`MODE_CMD_LSB+1:`MODE_CMD_LSB];
   end

   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN:
            if (mode_cmd_valid && mode_cmd == `MODE_CMD_HALT)
               state_next = ST_HALT;
            else if (mode_cmd_valid && mode_cmd == `MODE_CMD_HOLD)
               state_next = ST_HOLD;
            else if (mode_cmd_valid && mode_cmd == `MODE_CMD_XTAL_HOLD)
               state_next = ST_XHOLD;
         ST_HALT:
            if (any_irq_accepted)
               state_next = ST_RUN; // oscillators never stopped, no settling
         ST_HOLD:
            if (hold_wake)
               state_next = ST_SETTL;
         ST_XHOLD:
            if (xhold_wake)
               state_next = ST_SETTL;
         ST_SETTL:
            if (settle_reg == 16'h0000)
               state_next = ST_RUN;
         ST_RESET:
            if (rst_cnt_reg == 5'h00)
               state_next = ST_RUN;
         default:
            state_next = ST_RESET;
      endcase
      if (reset_wake)
         state_next = ST_RESET; // full reset on pin, watchdog, power
   end

   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_reg        <= ST_RESET;
         settle_reg       <= 16'h0000;
         rst_cnt_reg      <= SYS_RESET_CYCLES[4:0];
         wake_irq_pending <= 1'b0;
         xtal_keep_reg    <= 1'b1;
         power_save_reg   <= 1'b0;
         por_seen_reg     <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (power_on_detect)
            por_seen_reg <= 1'b1;
         if (state_next == ST_RESET && state_reg != ST_RESET)
            rst_cnt_reg <= SYS_RESET_CYCLES[4:0];
         else if (state_reg == ST_RESET && rst_cnt_reg != 5'h00)
            rst_cnt_reg <= rst_cnt_reg - 5'h01;
         // clears come first so a set in the same cycle still wins
         if (state_reg != ST_XHOLD)
            power_save_reg <= 1'b0;
         if (state_next == ST_RESET)
            wake_irq_pending <= 1'b0;
         else if (any_irq_accepted)
            wake_irq_pending <= 1'b0;
         if (mode_cmd_valid && mode_cmd == `MODE_CMD_XTAL_HOLD)
         begin
            xtal_keep_reg  <= xtal_en_reg; // freeze crystal state on entry
            power_save_reg <= avs_writedata[`MODE_POWER_SAVE_BIT];
         end
         if (state_next == ST_SETTL && state_reg != ST_SETTL)
         begin
            settle_reg       <= OSC_SETTLE_CYCLES[15:0];
            wake_irq_pending <= 1'b1; // resume with the waking interrupt pending
         end
         else if (state_reg == ST_SETTL && settle_reg != 16'h0000)
            settle_reg <= settle_reg - 16'h0001;
      end
   end

   // outputs from flip-flops
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cpu_run            <= 1'b0;
         periph_clk_en      <= 1'b0;
         base_timer_clk_en  <= 1'b0;
         ceramic_oscillator <= 1'b1;
         rc_osc_en          <= 1'b1;
         crystal_osc_en     <= 1'b1;
         var_rc_osc_en      <= 1'b1;
         power_save         <= 1'b0;
         system_reset       <= 1'b1;
      end
      else
      begin
         cpu_run            <= (state_next == ST_RUN); // halted in every standby mode
         periph_clk_en      <= (state_next == ST_RUN) | (state_next == ST_HALT);
         base_timer_clk_en  <= (state_next != ST_HOLD) & (state_next != ST_RESET);
         ceramic_oscillator <= (state_next != ST_HOLD) & (state_next != ST_XHOLD);
         rc_osc_en          <= (state_next != ST_HOLD) & (state_next != ST_XHOLD);
         var_rc_osc_en      <= (state_next != ST_HOLD) & (state_next != ST_XHOLD);
         if (state_next == ST_HOLD)
            crystal_osc_en <= 1'b0;
         else if (state_next == ST_XHOLD)
            crystal_osc_en <= (state_reg == ST_XHOLD) ? xtal_keep_reg : xtal_en_reg;
         else
            crystal_osc_en <= xtal_en_reg;
         power_save         <= (state_next == ST_XHOLD) &
                               (mode_cmd_valid ? avs_writedata[`MODE_POWER_SAVE_BIT] : power_save_reg);
         system_reset       <= (state_next == ST_RESET);
      end
   end

   // serial byte wake counts eight transfer clocks while frozen
   always @(posedge ref_clk)
   begin
      if (sys_rst || !serial_rx_active)
      begin
         serial_cnt_reg  <= 4'h0;
         serial_byte_reg <= 1'b0;
      end
      else if (state_reg == ST_SETTL || state_reg == ST_RUN)
         serial_byte_reg <= 1'b0;
      else if (serial_clk_edge)
      begin
         if (serial_cnt_reg == `SERIAL_BITS - 1)
         begin
            serial_cnt_reg  <= 4'h0;
            serial_byte_reg <= 1'b1;
         end
         else
            serial_cnt_reg <= serial_cnt_reg + 4'h1;
      end
   end

   // divider: 3 main-clock-equivalent ticks per 250 ns step, doubled per select step
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         div_cnt_reg   <= 12'h000;
         cycle_enable  <= 1'b0;
         xtal_prev_reg <= 1'b0;
      end
      else
      begin
         xtal_prev_reg <= crystal_in_pin;
         cycle_enable  <= 1'b0;
         // one base step is 10 ref_clk cycles = 250 ns at 40 MHz; 12 bits hold 10 << 8
         // gated on the next state so no cycle pulse slips out on a standby entry
         if (state_next == ST_RUN)
         begin
            if (div_cnt_reg >= (12'h00A << div_sel_reg) - 12'h001)
            begin
               div_cnt_reg  <= 12'h000;
               cycle_enable <= 1'b1;
            end
            else
               div_cnt_reg <= div_cnt_reg + 12'h001;
         end
      end
   end

   // register file
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         div_sel_reg  <= `CLK_DIV_RESET;
         xtal_en_reg  <= 1'b1;
         ack_reg      <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
         if (wr_sel && sel(avs_address, `ADDR_CLK_DIV))
         begin
            if (avs_writedata[3:0] <= `CLK_DIV_MAX)
               div_sel_reg <= avs_writedata[3:0]; // nine steps only, others ignored
         end
         if (wr_sel && sel(avs_address, `ADDR_MODE_CTRL))
            xtal_en_reg <= avs_writedata[`MODE_XTAL_EN_BIT];
         if (rd_sel)
         begin
            if (sel(avs_address, `ADDR_MODE_CTRL))
               avs_readdata <= {27'h0, 1'b0, xtal_en_reg, power_save_reg, 2'h0};
            else if (sel(avs_address, `ADDR_CLK_DIV))
               avs_readdata <= {28'h0, div_sel_reg};
            else if (sel(avs_address, `ADDR_STATUS))
               avs_readdata <= {21'h0, meas_busy, wake_irq_pending, low_voltage_detect_reset, 2'h0, state_reg};
            else if (sel(avs_address, `ADDR_FREQ_MEAS))
               avs_readdata <= {16'h0, meas_count};
            else
               avs_readdata <= 32'h0000_0000;
         end
      end
   end

   // measurement of the variable rc oscillator against the crystal input
   freq_meas_counter #(
      .GATE_EDGES (`MEAS_GATE_EDGES)
   ) u_freq_meas (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .start    (wr_sel & sel(avs_address, `ADDR_MODE_CTRL) & avs_writedata[`MODE_MEAS_START_BIT]),
      .osc_tick (var_rc_tick),
      .ref_edge (ref_edge),
      .busy     (meas_busy),
      .count    (meas_count)
   );
endmodule // standby_wake_reset_ctrl

// file: hdl/standby_wake_reset_ctrl_defines.vh
// constants for the standby, wake and reset sequencer
// assumes a 40 MHz ref_clk and a 32-bit avalon-mm register bus
`ifndef STANDBY_WAKE_RESET_CTRL_DEFINES_VH
`define STANDBY_WAKE_RESET_CTRL_DEFINES_VH

// register byte addresses
`define ADDR_MODE_CTRL      4'h0
`define ADDR_CLK_DIV        4'h4
`define ADDR_STATUS         4'h8
`define ADDR_FREQ_MEAS      4'hC

// mode control fields
`define MODE_CMD_LSB        0
`define MODE_CMD_HALT       2'h1
`define MODE_CMD_HOLD       2'h2
`define MODE_CMD_XTAL_HOLD  2'h3
`define MODE_POWER_SAVE_BIT 2
`define MODE_XTAL_EN_BIT    3
`define MODE_MEAS_START_BIT 4

// clock divider select: 0 gives 250 ns, 8 gives 64 us
`define CLK_DIV_RESET       4'h0
`define CLK_DIV_MAX         4'h8

// main clock and reference instruction cycle
`define MAIN_CLK_HZ         12000000
`define CYCLE_MIN_NS        250
`define MAIN_CLKS_PER_CYCLE 3

// oscillator stabilisation after a wake by interrupt
`define OSC_SETTLE_US       100
`define REF_CLK_MHZ         40
`define OSC_SETTLE_CYCLES   (`OSC_SETTLE_US * `REF_CLK_MHZ)

// system reset sequence length
`define SYS_RESET_CYCLES    16

// serial byte wake
`define SERIAL_BITS         8

// frequency measurement gate, in reference input edges
`define MEAS_GATE_EDGES     16'h0100

`endif

// file: verification/core_periph_model.sv
// behavioural cpu core and oscillator sources beside the sequencer
// assumes the shared ref_clk; irq_req is a level raised by the bench
module core_periph_model #(
   parameter int ACCEPT_DELAY = 3
)(
   input  wire  ref_clk,
   input  wire  irq_req,
   input  wire  cpu_run,
   input  wire  wake_irq_pending,
   input  wire  var_rc_osc_en,
   input  wire  crystal_osc_en,
   output logic any_irq_accepted,
   output logic var_rc_tick,
   output logic crystal_in_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_cnt = 0;
   logic phase = 1'b0;
   initial
   begin
      any_irq_accepted = 1'b0;
      var_rc_tick = 1'b0;
      crystal_in_pin = 1'b0;
   end
   always @(posedge ref_clk)
   begin
      phase <= !phase;
      // a stopped oscillator stands still, so no tick and no edge then
      var_rc_tick <= var_rc_osc_en && phase;
      if (phase)
         crystal_in_pin <= crystal_osc_en && !crystal_in_pin;
      // the core takes a pending wake or a halt interrupt a few cycles late
      wait_cnt <= (irq_req || (wake_irq_pending && cpu_run)) ? wait_cnt + 1 : 0;
      any_irq_accepted <= (wait_cnt == ACCEPT_DELAY);
   end
endmodule // core_periph_model

// file: verification/standby_wake_reset_ctrl_asserts.sv
// port checker for the standby, wake and reset sequencer
// assumes one ref_clk domain with synchronous active-high sys_rst; bound below
module standby_wake_reset_ctrl_asserts #(
   parameter int OSC_SETTLE_CYCLES = 20
)(
   input wire        ref_clk,
   input wire        sys_rst,
   input wire [3:0]  avs_address,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire        avs_waitrequest,
   input wire        reset_pin_n,
   input wire        watchdog_reset,
   input wire        power_on_detect,
   input wire        supply_low_detect,
   input wire        low_voltage_detect_reset,
   input wire        ext_irq_pin_a,
   input wire        port0_irq,
   input wire        cpu_run,
   input wire        periph_clk_en,
   input wire        base_timer_clk_en,
   input wire        ceramic_oscillator,
   input wire        rc_osc_en,
   input wire        crystal_osc_en,
   input wire        var_rc_osc_en,
   input wire        power_save,
   input wire        system_reset,
   input wire        wake_irq_pending,
   input wire        cycle_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // a mode write only counts when no reset source competes with it
   wire quiet = reset_pin_n && !watchdog_reset && !power_on_detect && !(supply_low_detect && low_voltage_detect_reset);
   wire wr_ok = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0] && cpu_run && quiet;
   wire [1:0] cmd = avs_writedata[1:0];
   logic in_hold = 1'b0;
   logic held = 1'b0;
   logic [15:0] settle_cnt = 16'h0000;
   always_ff @(posedge ref_clk)
   begin
      in_hold <= (wr_ok && cmd == 2'h2) || (in_hold && !ceramic_oscillator && !system_reset && !sys_rst);
      held <= (wr_ok && cmd[1]) || (held && !cpu_run && !system_reset && !sys_rst);
      settle_cnt <= (!cpu_run && ceramic_oscillator && !system_reset) ? settle_cnt + 16'h0001 : 16'h0000;
   end
   halt_entry_a: assert property (wr_ok && cmd == 2'h1 |=> !cpu_run && periph_clk_en && ceramic_oscillator
      && rc_osc_en && var_rc_osc_en) else $error("halt entry outputs wrong");
   hold_entry_a: assert property (wr_ok && cmd == 2'h2 |=> !cpu_run && !periph_clk_en && !base_timer_clk_en
      && !ceramic_oscillator && !rc_osc_en && !crystal_osc_en && !var_rc_osc_en) else $error("hold entry outputs wrong");
   xhold_entry_a: assert property (wr_ok && cmd == 2'h3 && avs_writedata[3] == crystal_osc_en
      |=> !cpu_run && !periph_clk_en && base_timer_clk_en && !ceramic_oscillator && !rc_osc_en && !var_rc_osc_en
      && crystal_osc_en == $past(crystal_osc_en) && power_save == $past(avs_writedata[2]))
      else $error("crystal hold entry outputs wrong");
   hold_wake_a: assert property (in_hold && (ext_irq_pin_a || port0_irq) |-> ##[1:3] ceramic_oscillator)
      else $error("hold did not end on a wake pin");
   settle_time_a: assert property (held && $rose(cpu_run) |-> settle_cnt >= OSC_SETTLE_CYCLES - 2 && wake_irq_pending)
      else $error("resumed before settling or without pending wake");
   osc_ready_a: assert property ($rose(cpu_run) |-> ceramic_oscillator && rc_osc_en && var_rc_osc_en)
      else $error("run resumed with an oscillator stopped");
   pin_reset_a: assert property (!reset_pin_n || watchdog_reset |-> ##[1:3] system_reset)
      else $error("reset source did not reset");
   reset_len_a: assert property ($rose(system_reset) |-> system_reset [*8])
      else $error("system reset too short");
   por_lvd_a: assert property (power_on_detect || (low_voltage_detect_reset && supply_low_detect)
      |-> ##[1:3] system_reset) else $error("power reset missing");
   no_lvd_a: assert property (!low_voltage_detect_reset && supply_low_detect && quiet && !system_reset
      |=> !system_reset) else $error("disabled low voltage reset fired");
   cycle_run_a: assert property (cycle_enable |-> cpu_run)
      else $error("instruction cycle while stopped");
endmodule // standby_wake_reset_ctrl_asserts

bind standby_wake_reset_ctrl standby_wake_reset_ctrl_asserts #(.OSC_SETTLE_CYCLES(OSC_SETTLE_CYCLES)) chk_u (
   .ref_clk, .sys_rst, .avs_address, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
   .reset_pin_n, .watchdog_reset, .power_on_detect, .supply_low_detect, .low_voltage_detect_reset,
   .ext_irq_pin_a, .port0_irq, .cpu_run, .periph_clk_en, .base_timer_clk_en, .ceramic_oscillator,
   .rc_osc_en, .crystal_osc_en, .var_rc_osc_en, .power_save, .system_reset, .wake_irq_pending, .cycle_enable);

// file: verification/tb_top.sv
// self-checking bench for the standby, wake and reset sequencer
// assumes the sequencer and core model; bus master per avalon-mm waitrequest
`include "standby_wake_reset_ctrl_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, irq_req = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic avs_waitrequest, any_irq_accepted, var_rc_tick, crystal_in_pin;
   logic reset_pin_n = 1'b1, watchdog_reset = 1'b0, power_on_detect = 1'b0, supply_low_detect = 1'b0;
   logic low_voltage_detect_reset = 1'b1, port0_irq = 1'b0, serial_clk_edge = 1'b0, serial_rx_active = 1'b0;
   logic base_timer_irq = 1'b0, calendar_irq = 1'b0;
   logic [5:0] ext_pins = 6'h00;
   logic cpu_run, periph_clk_en, base_timer_clk_en, ceramic_oscillator, rc_osc_en, crystal_osc_en;
   logic var_rc_osc_en, power_save, system_reset, wake_irq_pending, cycle_enable;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   standby_wake_reset_ctrl #(.OSC_SETTLE_CYCLES(20), .SYS_RESET_CYCLES(16)) dut_u (
      .ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
      .avs_readdata, .avs_waitrequest, .reset_pin_n, .watchdog_reset, .power_on_detect, .supply_low_detect,
      .low_voltage_detect_reset, .ext_irq_pin_a(ext_pins[0]), .ext_irq_pin_b(ext_pins[1]),
      .ext_irq_pin_c(ext_pins[2]), .ext_irq_pin_d(ext_pins[3]), .ext_irq_pin_e(ext_pins[4]),
      .ext_irq_pin_f(ext_pins[5]), .port0_irq, .serial_clk_edge, .serial_rx_active, .base_timer_irq,
      .calendar_irq, .any_irq_accepted, .var_rc_tick, .crystal_in_pin, .cpu_run, .periph_clk_en,
      .base_timer_clk_en, .ceramic_oscillator, .rc_osc_en, .crystal_osc_en, .var_rc_osc_en, .power_save,
      .system_reset, .wake_irq_pending, .cycle_enable);
   core_periph_model #(.ACCEPT_DELAY(3)) core_u (.ref_clk, .irq_req, .cpu_run, .wake_irq_pending,
      .var_rc_osc_en, .crystal_osc_en, .any_irq_accepted, .var_rc_tick, .crystal_in_pin);
   initial
   begin
      forever #12.5 ref_clk = !ref_clk;
   end
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // a hung wait ends the run here rather than spinning forever
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic wait_run(input int lim);
      for (int n = 0; n < lim && cpu_run !== 1'b1; n++) @(posedge ref_clk);
   endtask
   task automatic t_regs;
      logic [31:0] q;
      wait_run(40);
      bus(1'b0, `ADDR_STATUS, 32'h0, q);
      check({q[8], q[5:0]}, 7'h41);
      bus(1'b0, `ADDR_MODE_CTRL, 32'h0, q);
      check(q[3:0], 4'h8);
      bus(1'b0, 4'h2, 32'h0, q);
      check(q, 32'h0);
   endtask
   task automatic t_div;
      logic [31:0] q;
      realtime t0;
      for (int n = 0; n <= 8; n++)
      begin
         wr(`ADDR_CLK_DIV, n);
         repeat (2) @(posedge cycle_enable);
         t0 = $realtime;
         @(posedge cycle_enable);
         check(($realtime - t0) / 25.0, 10 << n);
      end
      wr(`ADDR_CLK_DIV, 32'h9);
      bus(1'b0, `ADDR_CLK_DIV, 32'h0, q);
      check(q[3:0], `CLK_DIV_MAX);
      wr(`ADDR_CLK_DIV, 32'h0);
   endtask
   task automatic t_halt;
      wr(`ADDR_MODE_CTRL, 32'h9);
      repeat (3) @(posedge ref_clk);
      check({cpu_run, periph_clk_en, ceramic_oscillator, rc_osc_en, var_rc_osc_en}, 5'h0F);
      irq_req <= 1'b1;
      wait_run(20);
      check(cpu_run, 1'b1);
      irq_req <= 1'b0;
   endtask
   // k picks the wake source; crystal hold when xh is set
   task automatic t_hold(input int k, input logic xh, input logic cx);
      wr(`ADDR_MODE_CTRL, {cx, 3'h0});
      wr(`ADDR_MODE_CTRL, xh ? {cx, 3'h7} : 32'hA);
      repeat (3) @(posedge ref_clk);
      check({periph_clk_en, ceramic_oscillator, rc_osc_en, var_rc_osc_en}, 4'h0);
      check({base_timer_clk_en, crystal_osc_en, power_save}, xh ? {1'b1, cx, 1'b1} : 3'h0);
      if (!xh)
         {base_timer_irq, calendar_irq} <= 2'h3;
      serial_rx_active <= (k == 7);
      repeat (4) @(posedge ref_clk);
      check(ceramic_oscillator, 1'b0);
      {base_timer_irq, calendar_irq} <= 2'h0;
      if (k < 6)
         ext_pins[k] <= 1'b1;
      port0_irq <= (k == 6);
      base_timer_irq <= (k == 8);
      calendar_irq <= (k == 9);
      for (int n = 0; k == 7 && n < 16; n++)
      begin
         serial_clk_edge <= !serial_clk_edge;
         @(posedge ref_clk);
         if (n == 13)
            check(ceramic_oscillator, 1'b0);
      end
      for (int n = 0; n < 8 && ceramic_oscillator !== 1'b1; n++) @(posedge ref_clk);
      {ext_pins, port0_irq, base_timer_irq, calendar_irq, serial_rx_active} <= 10'h000;
      check({ceramic_oscillator, cpu_run}, 2'h2);
      wait_run(40);
      check(wake_irq_pending, 1'b1);
      repeat (8) @(posedge ref_clk);
      check({cpu_run, wake_irq_pending}, 2'h2);
      wr(`ADDR_MODE_CTRL, 32'h8);
   endtask
   task automatic t_resets;
      for (int j = 0; j < 2; j++)
      begin
         wr(`ADDR_MODE_CTRL, j ? 32'h9 : 32'hA);
         repeat (3) @(posedge ref_clk);
         if (j)
            watchdog_reset <= 1'b1;
         else
            reset_pin_n <= 1'b0;
         repeat (4) @(posedge ref_clk);
         check(system_reset, 1'b1);
         {watchdog_reset, reset_pin_n} <= 2'h1;
         wait_run(60);
         check({cpu_run, wake_irq_pending}, 2'h2);
      end
   endtask
   task automatic t_power;
      logic [31:0] q;
      for (int j = 0; j < 3; j++)
      begin
         low_voltage_detect_reset <= (j != 2);
         if (j == 0)
            power_on_detect <= 1'b1;
         else
            supply_low_detect <= 1'b1;
         @(posedge ref_clk);
         {power_on_detect, supply_low_detect} <= 2'h0;
         repeat (3) @(posedge ref_clk);
         check(system_reset, j != 2);
         wait_run(60);
      end
      bus(1'b0, `ADDR_STATUS, 32'h0, q);
      check(q[8], 1'b0);
      low_voltage_detect_reset <= 1'b1;
   endtask
   task automatic t_meas;
      logic [31:0] q;
      wr(`ADDR_MODE_CTRL, 32'h18);
      q = 32'h400;
      for (int n = 0; n < 1000 && q[10] !== 1'b0; n++) bus(1'b0, `ADDR_STATUS, 32'h0, q);
      bus(1'b0, `ADDR_FREQ_MEAS, 32'h0, q);
      check(q[15:0] >= 16'h01FE && q[15:0] <= 16'h0202, 1'b1);
   endtask
   initial
   begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_div();
      t_halt();
      for (int k = 0; k < 8; k++) t_hold(k, 1'b0, 1'b1);
      for (int k = 0; k < 3; k++) t_hold(k == 2 ? 0 : k + 8, 1'b1, k != 1);
      t_resets();
      t_power();
      t_meas();
      print_verdict();
   end
endmodule // tb_top
